// File: design/fss_top.sv
// fault stop selection: response words, short-circuit words, AHB-Lite slave
// assumes fault inputs are levels synchronous to clk_sys, one AHB-Lite master
//
// Design decisions made here: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module fss_top #(
  parameter int unsigned W1 = 18,
  parameter int unsigned W2 = 24
) (
  input  wire logic                clk_sys,
  input  wire logic                rst,
  input  wire logic                motor_sync,
  input  wire fss_pkg::fss_ahb_req_s ahb_req,
  output fss_pkg::fss_ahb_rsp_s    ahb_rsp,
  input  wire logic [W1-1:0]       fault_one,
  input  wire logic [W2-1:0]       fault_two,
  output fss_pkg::fss_stop_s       stop,
  output logic                     irq
);
  import fss_pkg::*;

  // -----------------------------------------------------------------
  // elaboration checks
  // -----------------------------------------------------------------
  if (W1 != WORD_ONE_W) begin : g_chk_w1
    $error("fss_top: W1 must equal the first word width");
  end
  if (W2 != WORD_TWO_W) begin : g_chk_w2
    $error("fss_top: W2 must equal the second word width");
  end
  // motor defaults of the first word must lie inside its range
  if (SEL_ONE_RST_ASYNC > SEL_ONE_MAX || SEL_ONE_RST_SYNC > SEL_ONE_MAX) begin : g_chk_rst_one
    $error("fss_top: first word default above its maximum");
  end
  // motor defaults of the second word must lie inside its range
  if (SEL_TWO_RST_ASYNC > SEL_TWO_MAX || SEL_TWO_RST_SYNC > SEL_TWO_MAX) begin : g_chk_rst_two
    $error("fss_top: second word default above its maximum");
  end
  // assigned fault bits must fit the word widths
  if ((MAP_ONE >> W1) != 32'h0 || (MAP_TWO >> W2) != 32'h0) begin : g_chk_map
    $error("fss_top: fault map wider than its word");
  end
  // short-circuit maxima must fit the word widths
  if ((SC_ONE_MAX >> W1) != 32'h0 || (SC_TWO_MAX >> W2) != 32'h0) begin : g_chk_sc_max
    $error("fss_top: short-circuit maximum wider than its word");
  end
  // reaction positions must be bits of the event vector, short stop apart from the other two
  if (BIT_PULSE_CANCEL >= EVT_W || BIT_SHORT_STOP >= EVT_W || BIT_SECOND_STOP >= EVT_W ||
      BIT_PULSE_CANCEL == BIT_SHORT_STOP || BIT_SHORT_STOP == BIT_SECOND_STOP) begin : g_chk_pos
    $error("fss_top: reaction bit positions do not fit the event vector");
  end

  // -----------------------------------------------------------------
  // declarations
  // -----------------------------------------------------------------
  logic [31:0]       sel_one_q;
  logic [31:0]       sel_two_q;
  logic [31:0]       sc_one_q;
  logic [31:0]       sc_two_q;
  logic [EVT_W-1:0]  irq_stat_q;
  logic [EVT_W-1:0]  irq_stat_d;
  logic [EVT_W-1:0]  irq_en_q;
  logic              irq_q;
  logic [ADDR_W-1:0] addr_q;
  logic              wr_pend_q;
  logic              rd_wait_q;
  logic              hready_q;
  logic [31:0]       hrdata_q;
  logic              pc_q;
  logic              ss_q;
  logic              st_q;
  logic [W1-1:0]     act_one_q;
  logic [W2-1:0]     act_two_q;

  wire logic              pc_one;
  wire logic              ss_one;
  wire logic              st_one;
  wire logic              pc_two;
  wire logic              ss_two;
  wire logic              st_two;
  wire logic              pc_d;
  wire logic              ss_d;
  wire logic              st_d;
  wire logic [EVT_W-1:0]  evt;
  wire logic [EVT_W-1:0]  reaction;
  wire logic [EVT_W-1:0]  reaction_q;
  wire logic              addr_ph;
  wire logic              rd_ph;
  wire logic              wr_ph;
  wire logic [ADDR_W-1:0] haddr_lo;
  wire logic [ADDR_W-1:0] rd_addr;
  wire logic [31:0]       rd_mux;
  wire logic [31:0]       wdata;
  wire logic              wr_sel_one;
  wire logic              wr_sel_two;
  wire logic              wr_sc_one;
  wire logic              wr_sc_two;
  wire logic              wr_irq_clr;
  wire logic              wr_irq_en;
  wire logic              ok_sel_one;
  wire logic              ok_sel_two;
  wire logic              ok_sc_one;
  wire logic              ok_sc_two;
  wire logic [EVT_W-1:0]  clr_mask;

  // -----------------------------------------------------------------
  // reaction resolution, one resolver per response word
  // -----------------------------------------------------------------
  fss_resolve #(
    .W   (W1),
    .MAP (MAP_ONE)
  ) u_res_one (
    .fault        (fault_one),
    .sel          (sel_one_q[W1-1:0]),
    .sc           (sc_one_q[W1-1:0]),
    .pulse_cancel (pc_one),
    .short_stop   (ss_one),
    .second_stop  (st_one)
  );

  fss_resolve #(
    .W   (W2),
    .MAP (MAP_TWO)
  ) u_res_two (
    .fault        (fault_two),
    .sel          (sel_two_q[W2-1:0]),
    .sc           (sc_two_q[W2-1:0]),
    .pulse_cancel (pc_two),
    .short_stop   (ss_two),
    .second_stop  (st_two)
  );

  // merged reaction of both words
  assign pc_d = pc_one | pc_two;
  assign ss_d = ss_one | ss_two;
  assign st_d = st_one | st_two;

  // -----------------------------------------------------------------
  // reaction outputs
  // -----------------------------------------------------------------
  // registered stop levels, follow the faults one cycle later
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pc_q <= 1'b0;
      ss_q <= 1'b0;
      st_q <= 1'b0;
    end else begin
      pc_q <= pc_d;
      ss_q <= ss_d;
      st_q <= st_d;
    end
  end

  assign stop.pulse_cancel = pc_q;
  assign stop.short_stop   = ss_q;
  assign stop.second_stop  = st_q;

  // snapshot of active faults for software
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      act_one_q <= '0;
      act_two_q <= '0;
    end else begin
      act_one_q <= fault_one;
      act_two_q <= fault_two;
    end
  end

  // -----------------------------------------------------------------
  // bus phase decode
  // -----------------------------------------------------------------
  assign haddr_lo = ahb_req.haddr[ADDR_W-1:0];
  assign addr_ph  = ahb_req.hsel & ahb_req.htrans[1] & ahb_req.hready;
  assign rd_ph    = addr_ph & ~ahb_req.hwrite;
  assign wr_ph    = addr_ph & ahb_req.hwrite;
  assign wdata    = ahb_req.hwdata;

  // write strobes in the data phase of a captured write
  assign wr_sel_one = wr_pend_q & (addr_q == OFS_SEL_ONE);
  assign wr_sel_two = wr_pend_q & (addr_q == OFS_SEL_TWO);
  assign wr_sc_one  = wr_pend_q & (addr_q == OFS_SC_ONE);
  assign wr_sc_two  = wr_pend_q & (addr_q == OFS_SC_TWO);
  assign wr_irq_clr = wr_pend_q & (addr_q == OFS_IRQ_CLR);
  assign wr_irq_en  = wr_pend_q & (addr_q == OFS_IRQ_EN);

  // values above the accepted maximum are refused whole
  assign ok_sel_one = wdata <= SEL_ONE_MAX;
  assign ok_sel_two = wdata <= SEL_TWO_MAX;
  assign ok_sc_one  = wdata <= SC_ONE_MAX;
  assign ok_sc_two  = wdata <= SC_TWO_MAX;

  // -----------------------------------------------------------------
  // response words
  // -----------------------------------------------------------------
  // motor type defaults taken while reset is held
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sel_one_q <= motor_sync ? SEL_ONE_RST_SYNC : SEL_ONE_RST_ASYNC;
      sel_two_q <= motor_sync ? SEL_TWO_RST_SYNC : SEL_TWO_RST_ASYNC;
    end else begin
      if (wr_sel_one && ok_sel_one) begin
        sel_one_q <= wdata;
      end
      if (wr_sel_two && ok_sel_two) begin
        sel_two_q <= wdata;
      end
    end
  end

  // -----------------------------------------------------------------
  // short-circuit words
  // -----------------------------------------------------------------
  // bits land only where the response word holds zero
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sc_one_q <= SC_ONE_RST;
      sc_two_q <= SC_TWO_RST;
    end else begin
      if (wr_sc_one && ok_sc_one) begin
        sc_one_q <= wdata & ~sel_one_q;
      end
      if (wr_sc_two && ok_sc_two) begin
        sc_two_q <= wdata & ~sel_two_q;
      end
    end
  end

  // -----------------------------------------------------------------
  // interrupt status, enable and output
  // -----------------------------------------------------------------
  // rising edge of each stop level is one event
  assign reaction[BIT_PULSE_CANCEL]   = pc_d;
  assign reaction[BIT_SHORT_STOP]     = ss_d;
  assign reaction[BIT_SECOND_STOP]    = st_d;
  assign reaction_q[BIT_PULSE_CANCEL] = pc_q;
  assign reaction_q[BIT_SHORT_STOP]   = ss_q;
  assign reaction_q[BIT_SECOND_STOP]  = st_q;
  assign evt      = reaction & ~reaction_q;
  assign clr_mask = wr_irq_clr ? wdata[EVT_W-1:0] : '0;

  // set wins over a clear in the same cycle
  assign irq_stat_d = (irq_stat_q & ~clr_mask) | evt;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_stat_q <= '0;
      irq_en_q   <= IRQ_EN_RST;
      irq_q      <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq_q      <= |(irq_stat_d & irq_en_q);
      if (wr_irq_en) begin
        irq_en_q <= wdata[EVT_W-1:0];
      end
    end
  end

  assign irq = irq_q;

  // -----------------------------------------------------------------
  // read multiplexer
  // -----------------------------------------------------------------
  // a stalled read uses the held address, otherwise the live one
  assign rd_addr = rd_wait_q ? addr_q : haddr_lo;

  assign rd_mux =
    (rd_addr == OFS_SEL_ONE)  ? sel_one_q :
    (rd_addr == OFS_SEL_TWO)  ? sel_two_q :
    (rd_addr == OFS_SC_ONE)   ? sc_one_q :
    (rd_addr == OFS_SC_TWO)   ? sc_two_q :
    (rd_addr == OFS_IRQ_STAT) ? {{(32-EVT_W){1'b0}}, irq_stat_q} :
    (rd_addr == OFS_IRQ_EN)   ? {{(32-EVT_W){1'b0}}, irq_en_q} :
    (rd_addr == OFS_REACTION) ? {{(32-EVT_W){1'b0}}, reaction_q} :
    (rd_addr == OFS_ACT_ONE)  ? {{(32-W1){1'b0}}, act_one_q} :
    (rd_addr == OFS_ACT_TWO)  ? {{(32-W2){1'b0}}, act_two_q} :
    32'h00000000; // unmapped and write-only read as zero

  // -----------------------------------------------------------------
  // bus phase tracking
  // -----------------------------------------------------------------
  // a read behind a write waits one cycle so it sees the new value
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      addr_q    <= '0;
      wr_pend_q <= 1'b0;
      rd_wait_q <= 1'b0;
    end else begin
      wr_pend_q <= wr_ph;
      rd_wait_q <= rd_ph & wr_pend_q;
      if (addr_ph) begin
        addr_q <= haddr_lo;
      end
    end
  end

  // -----------------------------------------------------------------
  // bus response
  // -----------------------------------------------------------------
  // ready drops only for the read-after-write stall
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hready_q <= 1'b1;
      hrdata_q <= 32'h00000000;
    end else begin
      hready_q <= ~(rd_ph & wr_pend_q);
      if ((rd_ph && !wr_pend_q) || rd_wait_q) begin
        hrdata_q <= rd_mux;
      end
    end
  end

  assign ahb_rsp.hreadyout = hready_q;
  assign ahb_rsp.hresp     = 1'b0;
  assign ahb_rsp.hrdata    = hrdata_q;

endmodule : fss_top

// File: design/fss_pkg.sv
// constants, register map and carriers for the fault stop selection block
// assumes one clock, synchronous active-high reset and an AHB-Lite master
// Function
// - word one bits map faults 501..517
// - word two bit n maps fault 600+n
// - response bit set: pulse cancellation stop
// - response bit clear: consult short-circuit word
// - short-circuit one: 1 short stop, 0 second
// - short-circuit one bit needs response bit zero
// - short-circuit two: 1 short stop, 0 second
// - short-circuit two bit needs response bit zero
// - response one defaults per motor, max 3ffff
// - response two defaults per motor, max ffffff
// - short-circuit one resets zero, max 3fff
// - short-circuit two resets zero, max ffffff
package fss_pkg;

  // -----------------------------------------------------------------
  // widths
  // -----------------------------------------------------------------
  localparam int unsigned WORD_ONE_W = 18;
  localparam int unsigned WORD_TWO_W = 24;
  localparam int unsigned ADDR_W     = 8;

  // -----------------------------------------------------------------
  // register offsets (byte addresses)
  // -----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_SEL_ONE   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_SEL_TWO   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_SC_ONE    = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_SC_TWO    = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLR   = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN    = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_REACTION  = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_ACT_ONE   = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_ACT_TWO   = 8'h24;

  // -----------------------------------------------------------------
  // reset values and accepted maxima
  // -----------------------------------------------------------------
  localparam logic [31:0] SEL_ONE_RST_ASYNC = 32'h0001f3b2;
  localparam logic [31:0] SEL_ONE_RST_SYNC  = 32'h0000f3b2;
  localparam logic [31:0] SEL_ONE_MAX       = 32'h0003ffff;
  localparam logic [31:0] SEL_TWO_RST_ASYNC = 32'h003f7fcc;
  localparam logic [31:0] SEL_TWO_RST_SYNC  = 32'h003f0100;
  localparam logic [31:0] SEL_TWO_MAX       = 32'h00ffffff;
  localparam logic [31:0] SC_ONE_RST        = 32'h00000000;
  localparam logic [31:0] SC_ONE_MAX        = 32'h00003fff;
  localparam logic [31:0] SC_TWO_RST        = 32'h00000000;
  localparam logic [31:0] SC_TWO_MAX        = 32'h00ffffff;

  // -----------------------------------------------------------------
  // assigned fault bits per word
  // -----------------------------------------------------------------
  localparam logic [31:0] MAP_ONE = 32'h0003f3b2;
  localparam logic [31:0] MAP_TWO = 32'h00ffffec;

  // -----------------------------------------------------------------
  // reaction and interrupt field positions
  // -----------------------------------------------------------------
  localparam int unsigned BIT_PULSE_CANCEL = 0;
  localparam int unsigned BIT_SHORT_STOP   = 1;
  localparam int unsigned BIT_SECOND_STOP  = 2;
  localparam int unsigned EVT_W            = 3;
  localparam logic [EVT_W-1:0] IRQ_EN_RST  = 3'h0;

  // -----------------------------------------------------------------
  // carriers
  // -----------------------------------------------------------------
  typedef struct packed {
    logic              hsel;
    logic [31:0]       haddr;
    logic [1:0]        htrans;
    logic              hwrite;
    logic [2:0]        hsize;
    logic [31:0]       hwdata;
    logic              hready;
  } fss_ahb_req_s;

  typedef struct packed {
    logic              hreadyout;
    logic              hresp;
    logic [31:0]       hrdata;
  } fss_ahb_rsp_s;

  typedef struct packed {
    logic              second_stop;
    logic              short_stop;
    logic              pulse_cancel;
  } fss_stop_s;

endpackage : fss_pkg

// File: design/fss_resolve.sv
// per-bit stop reaction resolution for one fault word
// assumes combinational use inside the fault stop selection top
`timescale 1ns/1ns
module fss_resolve #(
  parameter int unsigned W   = 18,
  parameter logic [31:0] MAP = 32'h0003f3b2
) (
  input  wire logic [W-1:0] fault,
  input  wire logic [W-1:0] sel,
  input  wire logic [W-1:0] sc,
  output logic              pulse_cancel,
  output logic              short_stop,
  output logic              second_stop
);

  logic [W-1:0] pc_vec;
  logic [W-1:0] ss_vec;
  logic [W-1:0] st_vec;

  // the map parameter holds 32 bits, wider words cannot be served
  if (W < 1 || W > 32) begin : g_chk_w
    $error("fss_resolve: W must lie between 1 and 32");
  end

  // -----------------------------------------------------------------
  // one resolver per fault bit
  // -----------------------------------------------------------------
  for (genvar i = 0; i < W; i++) begin : g_bit
    wire logic hit = fault[i] & MAP[i];
    assign pc_vec[i] = hit & sel[i];
    assign ss_vec[i] = hit & ~sel[i] & sc[i];
    assign st_vec[i] = hit & ~sel[i] & ~sc[i];
  end

  // any fault of a class raises that reaction
  assign pulse_cancel = |pc_vec;
  assign short_stop   = |ss_vec;
  assign second_stop  = |st_vec;

endmodule : fss_resolve

// File: sim/fss_top_asserts.sv
// port-level checker for the fault stop selection top
// assumes it is bound onto fss_top by the bench top
`timescale 1ns/1ns
module fss_top_asserts
  import fss_pkg::*;
#(
  parameter int unsigned W1 = 18,
  parameter int unsigned W2 = 24
) (
  input wire logic                   clk_sys,
  input wire logic                   rst,
  input wire logic                   motor_sync,
  input wire fss_pkg::fss_ahb_req_s  ahb_req,
  input wire fss_pkg::fss_ahb_rsp_s  ahb_rsp,
  input wire logic [W1-1:0]          fault_one,
  input wire logic [W2-1:0]          fault_two,
  input wire fss_pkg::fss_stop_s     stop,
  input wire logic                   irq
);
  // -----------------------------------------------------------------
  // helper terms
  // -----------------------------------------------------------------
  logic [W1+W2-1:0] hits;
  logic             any_stop;
  logic             wr_take;
  logic             rd_take;

  // assigned fault bits only, and taken bus requests
  assign hits     = {fault_one & MAP_ONE[W1-1:0], fault_two & MAP_TWO[W2-1:0]};
  assign any_stop = |stop;
  assign wr_take  = ahb_req.hsel & ahb_req.htrans[1] & ahb_req.hready & ahb_req.hwrite;
  assign rd_take  = ahb_req.hsel & ahb_req.htrans[1] & ahb_req.hready & ~ahb_req.hwrite;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_fault;
    |hits;
  endsequence

  sequence s_quiet;
    hits == '0;
  endsequence

  // -----------------------------------------------------------------
  // properties
  // -----------------------------------------------------------------
  chk_reset_quiet: assert property (disable iff (1'b0) rst |=> !any_stop && !irq)
    else $error("outputs active after reset");
  chk_unassigned_quiet: assert property (s_quiet |=> !any_stop)
    else $error("stop without assigned fault");
  chk_fault_stops: assert property (s_fault |=> any_stop)
    else $error("assigned fault gave no stop");
  chk_one_class: assert property ($onehot(hits) |=> $onehot(stop))
    else $error("single fault gave not one stop class");
  chk_stop_cause: assert property ($rose(any_stop) |-> $past(|hits))
    else $error("stop rose without fault");
  chk_write_nowait: assert property (wr_take |=> ahb_rsp.hreadyout)
    else $error("write data phase stalled");
  chk_stall_cause: assert property (!ahb_rsp.hreadyout |-> $past(rd_take) && $past(wr_take, 2))
    else $error("stall without read after write");
  chk_irq_fall: assert property ($fell(irq) |-> $past(wr_take, 2) || $past(wr_take, 3))
    else $error("irq fell without a write");
  chk_irq_rise: assert property ($rose(irq) |-> any_stop || $past(wr_take, 2) || $past(wr_take, 3))
    else $error("irq rose without cause");
endmodule : fss_top_asserts

// File: sim/fss_fault_model.sv
// fault monitor model: registered fault levels toward the block
// assumes the bench sets wanted levels just after a clock edge
`timescale 1ns/1ns
module fss_fault_model #(
  parameter int unsigned W1 = 18,
  parameter int unsigned W2 = 24
) (
  input  wire logic          clk_sys,
  input  wire logic          rst,
  input  wire logic [W1-1:0] want_one,
  input  wire logic [W2-1:0] want_two,
  output logic      [W1-1:0] fault_one,
  output logic      [W2-1:0] fault_two
);
  // monitors report clean levels synchronous to the clock
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fault_one <= '0;
      fault_two <= '0;
    end else begin
      fault_one <= want_one;
      fault_two <= want_two;
    end
  end
endmodule : fss_fault_model

// File: sim/tb_fss_top.sv
// self-checking bench for the fault stop selection top
// assumes the checker and fault model files are compiled first
`timescale 1ns/1ns
module tb_fss_top;
  import fss_pkg::*;
  // -----------------------------------------------------------------
  // signals
  // -----------------------------------------------------------------
  localparam logic [31:0] MAP1 = 32'h0003f3b2;
  localparam logic [31:0] MAP2 = 32'h00ffffec;
  logic         clk_sys    = 1'b0;
  logic         rst        = 1'b1;
  logic         motor_sync = 1'b0;
  logic         hsel       = 1'b0;
  logic [31:0]  haddr      = 32'h0;
  logic [1:0]   htrans     = 2'h0;
  logic         hwrite     = 1'b0;
  logic [31:0]  hwdata     = 32'h0;
  logic [17:0]  want_one   = 18'h0;
  logic [23:0]  want_two   = 24'h0;
  logic [17:0]  fault_one;
  logic [23:0]  fault_two;
  fss_ahb_req_s ahb_req;
  fss_ahb_rsp_s ahb_rsp;
  fss_stop_s    stop;
  logic         irq;
  logic [31:0]  rd;
  logic [31:0]  s1;
  logic [31:0]  s2;
  logic [31:0]  c1;
  logic [31:0]  c2;
  int           n_errors   = 0;
  int           tests_run  = 0;
  int           cycles     = 0;

  always #2 clk_sys = ~clk_sys;
  // one slave, so its ready is the bus ready
  assign ahb_req = '{hsel, haddr, htrans, hwrite, 3'h2, hwdata, ahb_rsp.hreadyout};

  fss_top #(.W1(18), .W2(24)) i_dut (.clk_sys(clk_sys), .rst(rst), .motor_sync(motor_sync),
    .ahb_req(ahb_req), .ahb_rsp(ahb_rsp), .fault_one(fault_one), .fault_two(fault_two),
    .stop(stop), .irq(irq));
  fss_fault_model #(.W1(18), .W2(24)) i_mon (.clk_sys(clk_sys), .rst(rst), .want_one(want_one),
    .want_two(want_two), .fault_one(fault_one), .fault_two(fault_two));

  // -----------------------------------------------------------------
  // tasks
  // -----------------------------------------------------------------
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t word got %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_level(input logic [2:0] got, input logic [2:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t level got %h expected %h", $time, got, exp);
    end
  endtask : chk_level

  task automatic wait_rdy();
    do @(posedge clk_sys); while (ahb_rsp.hreadyout !== 1'b1);
  endtask : wait_rdy

  // one single transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = ahb_rsp.hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk_word(rd, exp);
  endtask : rchk

  task automatic do_reset(input logic ms);
    @(posedge clk_sys);
    rst        <= 1'b1;
    motor_sync <= ms;
    repeat (12) @(posedge clk_sys);
    rst        <= 1'b0;
  endtask : do_reset

  // pulse cancel, short stop, second stop as bits 0, 1, 2
  function automatic logic [2:0] expect_stop(input logic sel, input logic sc, input logic map);
    if (!map) return 3'h0;
    if (sel) return 3'h1;
    return sc ? 3'h2 : 3'h4;
  endfunction : expect_stop

  // fault levels pass the monitor, then the stop register
  task automatic fault_chk(input logic [17:0] f1, input logic [23:0] f2, input logic [2:0] exp);
    @(posedge clk_sys);
    want_one <= f1;
    want_two <= f2;
    repeat (3) @(posedge clk_sys);
    #1;
    chk_level(stop, exp);
  endtask : fault_chk

  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial begin
    do_reset(1'b0);
    rchk(OFS_SEL_ONE, 32'h0001f3b2);
    rchk(OFS_SEL_TWO, 32'h003f7fcc);
    rchk(OFS_SC_ONE, 32'h0);
    rchk(OFS_SC_TWO, 32'h0);
    rchk(8'h40, 32'h0);
    do_reset(1'b1);
    rchk(OFS_SEL_ONE, 32'h0000f3b2);
    rchk(OFS_SEL_TWO, 32'h003f0100);
    $display("test reset_values done");
    wr(OFS_SEL_ONE, 32'h00040000);
    rchk(OFS_SEL_ONE, 32'h0000f3b2);
    wr(OFS_SEL_ONE, 32'h0003ffff);
    rchk(OFS_SEL_ONE, 32'h0003ffff);
    wr(OFS_SEL_TWO, 32'h01000000);
    rchk(OFS_SEL_TWO, 32'h003f0100);
    wr(OFS_SC_ONE, 32'h00004000);
    rchk(OFS_SC_ONE, 32'h0);
    wr(OFS_SC_TWO, 32'h01000000);
    rchk(OFS_SC_TWO, 32'h0);
    $display("test limits done");
    s1 = 32'h0000f002;
    s2 = 32'h00ff0200;
    wr(OFS_SEL_ONE, s1);
    wr(OFS_SEL_TWO, s2);
    wr(OFS_SC_ONE, 32'h00003fff);
    wr(OFS_SC_TWO, 32'h0000f3ff);
    c1 = 32'h00003fff & ~s1;
    c2 = 32'h0000f3ff & ~s2;
    rchk(OFS_SC_ONE, c1);
    rchk(OFS_SC_TWO, c2);
    for (int b = 0; b < 18; b++) begin
      fault_chk(18'h1 << b, 24'h0, expect_stop(s1[b], c1[b], MAP1[b]));
    end
    for (int b = 0; b < 24; b++) begin
      fault_chk(18'h0, 24'h1 << b, expect_stop(s2[b], c2[b], MAP2[b]));
    end
    fault_chk(18'h10012, 24'h0, 3'h7);
    fault_chk(18'h0, 24'h0, 3'h0);
    $display("test fault_map done");
    // enabled event raises irq, clear drops it, masked event stays silent
    wr(OFS_IRQ_CLR, 32'h7);
    rchk(OFS_IRQ_STAT, 32'h0);
    wr(OFS_IRQ_EN, 32'h1);
    rchk(OFS_IRQ_EN, 32'h1);
    fault_chk(18'h1000, 24'h0, 3'h1);
    chk_level({2'h0, irq}, 3'h1);
    rchk(OFS_IRQ_STAT, 32'h1);
    fault_chk(18'h0, 24'h0, 3'h0);
    wr(OFS_IRQ_CLR, 32'h1);
    rchk(OFS_IRQ_STAT, 32'h0);
    chk_level({2'h0, irq}, 3'h0);
    fault_chk(18'h10000, 24'h0, 3'h4);
    chk_level({2'h0, irq}, 3'h0);
    rchk(OFS_IRQ_STAT, 32'h4);
    rchk(OFS_REACTION, 32'h4);
    rchk(OFS_ACT_ONE, 32'h00010000);
    rchk(OFS_ACT_TWO, 32'h0);
    wr(OFS_IRQ_EN, 32'h4);
    rchk(OFS_IRQ_EN, 32'h4);
    chk_level({2'h0, irq}, 3'h1);
    wr(OFS_IRQ_CLR, 32'h4);
    rchk(OFS_IRQ_STAT, 32'h0);
    chk_level({2'h0, irq}, 3'h0);
    $display("test interrupt done");
    test_done();
  end

  // hang guard, far above the expected run length
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors++;
      $display("ERROR %0t run did not finish", $time);
      test_done();
    end
  end
endmodule : tb_fss_top

bind fss_top fss_top_asserts #(.W1(W1), .W2(W2)) i_chk (.clk_sys(clk_sys), .rst(rst),
  .motor_sync(motor_sync), .ahb_req(ahb_req), .ahb_rsp(ahb_rsp), .fault_one(fault_one),
  .fault_two(fault_two), .stop(stop), .irq(irq));
